// *** bench/pad_partner.sv ***
// Far-side model of port C: pad resolution plus an external reset source on the shared pin
module pad_partner
  import sys_ctrl_pkg::*;
(
  input logic pclk,
  input logic [7:0] c_o,
  input logic [7:0] c_oe,
  input logic [7:0] c_pu,
  output logic [7:0] c_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Undriven, unpulled lines toggle so a stale value never looks valid
  logic [7:0] ext = 8'h5a;
  always @(posedge pclk) begin
    ext <= ~ext;
    if (cnt > 0) cnt <= cnt - 1;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (c_oe[i]) c_in[i] = c_o[i];
      else if (i == SHARED_RESET_BIT && cnt != 0) c_in[i] = 1'b0;
      else if (c_pu[i]) c_in[i] = 1'b1;
      else c_in[i] = ext[i];
    end
  end
  // Only start a new low while idle, so the counter never sees two writes in one step
  task automatic pull_low(input int n);
    cnt <= n;
  endtask
endmodule

// *** bench/reset_pin_and_sleep_control_bench.sv ***
// Self-checking bench for the reset pin and sleep control block
module reset_pin_and_sleep_control_bench
  import sys_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic reset_pin_disable_fuse = 1'b0;
  logic clock_pin_select_fuse = 1'b0;
  logic sleep_cmd = 1'b0;
  logic wake_irq = 1'b0;
  logic [3:0] port_a_pins_i = 4'h0;
  logic [7:0] port_b_pins_i = 8'h00;
  logic [7:0] port_d_pins_i = 8'h3c;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, clock_gen_in, chip_reset, cpu_clk_en, io_clk_en, adc_clk_en, osc_en;
  logic [3:0] port_a_pins_o, port_a_pins_oe, port_a_pins_pu;
  logic [7:0] port_b_pins_o, port_b_pins_oe, port_b_pins_pu, port_c_pins_i, port_c_pins_o;
  logic [7:0] port_c_pins_oe, port_c_pins_pu, port_d_pins_o, port_d_pins_oe, port_d_pins_pu;
  int n_errors = 0;
  int checked = 0;
  always #5 pclk = ~pclk;
  // Short counts keep the run brief; expectations below follow these values
  reset_pin_and_sleep_control #(.MIN_PULSE_CYCLES(4), .HOLD_CYCLES(3), .OSC_CYCLES(3)) dut (.*);
  pad_partner ext (.pclk(pclk), .c_o(port_c_pins_o), .c_oe(port_c_pins_oe), .c_pu(port_c_pins_pu), .c_in(port_c_pins_i));

  task automatic give_verdict;
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_errors++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait on chip_reset (sel 0) or cpu_clk_en (sel 1)
  task automatic wait_for(input bit sel, input logic want);
    int i;
    i = 0;
    while ((sel ? cpu_clk_en : chip_reset) !== want && i < 300) begin
      @(posedge pclk);
      i++;
    end
    if (i >= 300) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic t_regs;
    apb(1, 8'h10, 32'hff);
    apb(0, 8'h10, 32'h0);
    chk("port a dir", 32'h0f, rd);
    apb(1, 8'h18, 32'h06);
    apb(1, 8'h14, 32'hfc);
    apb(1, 8'h10, 32'h03);
    apb(1, 8'h20, 32'hff);
    apb(1, 8'h24, 32'ha5);
    apb(1, 8'h40, 32'h80);
    apb(1, 8'h48, 32'h7f);
    apb(1, 8'h44, 32'h81);
    @(negedge pclk);
    chk("port a pads", 32'hc43, {20'h0, port_a_pins_o, port_a_pins_pu, port_a_pins_oe});
    chk("port b pads", 32'hffa5, {16'h0, port_b_pins_oe, port_b_pins_o});
    chk("port d pads", 32'h817f80, {8'h0, port_d_pins_o, port_d_pins_pu, port_d_pins_oe});
    apb(0, 8'h80, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    apb(0, STATUS_OFFSET, 32'h0);
    chk("status", 32'h201, rd);
  endtask
  task automatic t_ce;
    port_a_pins_i <= 4'ha;
    port_d_pins_i <= 8'hc3;
    apb(1, SLEEP_CTRL_OFFSET, 32'h1);
    apb(0, 8'h1c, 32'h0);
    chk("port a pins", 32'h0a, rd);
    apb(0, 8'h4c, 32'h0);
    chk("port d pins", 32'hc3, rd);
    // A sleep request while the enable is low must leave the state untouched
    ce <= 1'b0;
    @(posedge pclk);
    sleep_cmd <= 1'b1;
    @(posedge pclk);
    sleep_cmd <= 1'b0;
    @(posedge pclk);
    ce <= 1'b1;
    @(negedge pclk);
    chk("frozen sleep", 32'h1, 32'(cpu_clk_en));
  endtask
  task automatic t_pin;
    ext.pull_low(8);
    repeat (3) @(posedge pclk);
    chk("pin reset", 32'h1, 32'(chip_reset));
    chk("pin reset hiz", 32'h0, {24'h0, port_b_pins_oe});
    wait_for(0, 1'b0);
    apb(0, STATUS_OFFSET, 32'h0);
    chk("long flag", 32'h301, rd);
    apb(1, STATUS_OFFSET, 32'h100);
    ext.pull_low(2);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    apb(0, STATUS_OFFSET, 32'h0);
    chk("short pulse", 32'h201, rd);
  endtask
  task automatic t_fuse;
    reset_pin_disable_fuse <= 1'b1;
    clock_pin_select_fuse <= 1'b1;
    apb(1, 8'h30, 32'h40);
    @(negedge pclk);
    chk("pc6 as output", 32'h40, {24'h0, port_c_pins_oe});
    apb(1, 8'h30, 32'h0);
    ext.pull_low(6);
    repeat (8) @(posedge pclk);
    chk("no pin reset", 32'h0, 32'(chip_reset));
    apb(0, STATUS_OFFSET, 32'h0);
    chk("fuse status", 32'h401, rd);
    port_b_pins_i <= 8'h40;
    @(negedge pclk);
    chk("clock pin", 32'h1bf, {23'h0, clock_gen_in, port_b_pins_oe});
    @(posedge pclk);
    port_b_pins_i <= 8'h00;
    // Pull PC6 up first so handing it back to the reset role shows no false low
    apb(1, 8'h38, 32'h40);
    reset_pin_disable_fuse <= 1'b0;
    clock_pin_select_fuse <= 1'b0;
  endtask
  task automatic t_sleep;
    logic [2:0] cfg [5] = '{3'h1, 3'h3, 3'h5, 3'h7, 3'h4};
    logic [3:0] exp [5] = '{4'b0111, 4'b0011, 4'b0000, 4'b1111, 4'b1111};
    for (int m = 0; m < 5; m++) begin
      apb(1, SLEEP_CTRL_OFFSET, {29'h0, cfg[m]});
      @(posedge pclk);
      sleep_cmd <= 1'b1;
      @(posedge pclk);
      sleep_cmd <= 1'b0;
      @(negedge pclk);
      chk("sleep enables", {28'h0, exp[m]}, {28'h0, cpu_clk_en, io_clk_en, adc_clk_en, osc_en});
      repeat (3) @(posedge pclk);
      wake_irq <= 1'b1;
      @(posedge pclk);
      wake_irq <= 1'b0;
      wait_for(1, 1'b1);
    end
    apb(0, 8'h24, 32'h0);
    chk("kept port b out", 32'ha5, rd);
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    chk("reset hiz", 32'h0, {4'h0, port_a_pins_oe, port_b_pins_oe, port_c_pins_oe, port_d_pins_oe});
    chk("pc6 pull-up", 32'h1, 32'(port_c_pins_pu[SHARED_RESET_BIT]));
    presetn <= 1'b1;
    wait_for(0, 1'b0);
    t_regs();
    t_ce();
    t_pin();
    t_fuse();
    t_sleep();
    give_verdict();
  end
endmodule

// *** bench/sleep_chk.sv ***
// Port-level assertions for the reset pin and sleep control block
module sleep_chk
  import sys_ctrl_pkg::*;
#(
  parameter int OSC_CYCLES = OSC_START_CYCLES
) (
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic reset_pin_disable_fuse,
  input logic clock_pin_select_fuse,
  input logic sleep_cmd,
  input logic wake_irq,
  input logic [PORT_B_WIDTH-1:0] port_b_pins_i,
  input logic [PORT_C_WIDTH-1:0] port_c_pins_i,
  input logic [PORT_A_WIDTH-1:0] port_a_pins_oe,
  input logic [PORT_B_WIDTH-1:0] port_b_pins_oe,
  input logic [PORT_C_WIDTH-1:0] port_c_pins_oe,
  input logic [PORT_D_WIDTH-1:0] port_d_pins_oe,
  input logic clock_gen_in,
  input logic chip_reset,
  input logic cpu_clk_en,
  input logic io_clk_en,
  input logic adc_clk_en,
  input logic osc_en
);
  localparam int OSC_HI = OSC_CYCLES - 1;
  logic [2:0] sleep_cfg;
  logic [3:0] en;
  logic go;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign en = {cpu_clk_en, io_clk_en, adc_clk_en, osc_en};
  assign go = sleep_cmd && ce && !chip_reset && en == 4'hf;
  // Shadow of the sleep word, since the mode is not visible at the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sleep_cfg <= 3'h0;
    else if (ce && psel && penable && pwrite && paddr == SLEEP_CTRL_OFFSET) sleep_cfg <= pwdata[2:0];
  end
  property p_rst_hiz;
    chip_reset |-> {port_a_pins_oe, port_b_pins_oe, port_c_pins_oe, port_d_pins_oe} == 28'h0;
  endproperty
  a_rst_hiz: assert property (p_rst_hiz) else $error("pins driven in reset");
  property p_pin_rst;
    !reset_pin_disable_fuse && !port_c_pins_i[SHARED_RESET_BIT] |-> chip_reset;
  endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("low reset pin ignored");
  property p_pin_role;
    !reset_pin_disable_fuse |-> !port_c_pins_oe[SHARED_RESET_BIT];
  endproperty
  a_pin_role: assert property (p_pin_role) else $error("reset pin driven");
  property p_gpio;
    reset_pin_disable_fuse && !chip_reset |=> !chip_reset;
  endproperty
  a_gpio: assert property (p_gpio) else $error("reset from gpio pin");
  property p_clk_pin;
    clock_gen_in == (clock_pin_select_fuse && port_b_pins_i[CLOCK_PIN_BIT]);
  endproperty
  a_clk_pin: assert property (p_clk_pin) else $error("clock pin path wrong");
  property p_idle;
    go && sleep_cfg == 3'h1 |=> en == 4'b0111;
  endproperty
  a_idle: assert property (p_idle) else $error("idle enables wrong");
  property p_adc;
    go && sleep_cfg == 3'h3 |=> en == 4'b0011;
  endproperty
  a_adc: assert property (p_adc) else $error("adc mode enables wrong");
  property p_pd;
    go && sleep_cfg == 3'h5 |=> (en == 4'h0) [*2];
  endproperty
  a_pd: assert property (p_pd) else $error("power-down enables wrong");
  property p_rsvd;
    go && sleep_cfg[0] && sleep_cfg[2:1] == 2'h3 |=> en == 4'hf;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mode slept");
  property p_wake;
    en == 4'h0 && wake_irq && ce && !chip_reset |=> (en == 4'h1) [*3] ##[1:OSC_HI] en == 4'hf;
  endproperty
  a_wake: assert property (p_wake) else $error("wake sequence wrong");
endmodule

bind reset_pin_and_sleep_control sleep_chk #(.OSC_CYCLES(OSC_CYCLES)) u_chk (.*);

// *** verilog/reset_pin_and_sleep_control.sv ***
// Top level: shared reset pin, port pad control and sleep mode sequencing
//
// Chosen here: the APB interface to the registers and the address map.
module reset_pin_and_sleep_control
  import sys_ctrl_pkg::*;
#(
  parameter int MIN_PULSE_CYCLES = MIN_RESET_PULSE_CYCLES,
  parameter int HOLD_CYCLES = RESET_HOLD_CYCLES,
  parameter int OSC_CYCLES = OSC_START_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_disable_fuse,
  input wire logic clock_pin_select_fuse,
  input wire logic sleep_cmd,
  input wire logic wake_irq,
  input wire logic [PORT_A_WIDTH-1:0] port_a_pins_i,
  output logic [PORT_A_WIDTH-1:0] port_a_pins_o,
  output logic [PORT_A_WIDTH-1:0] port_a_pins_oe,
  output logic [PORT_A_WIDTH-1:0] port_a_pins_pu,
  input wire logic [PORT_B_WIDTH-1:0] port_b_pins_i,
  output logic [PORT_B_WIDTH-1:0] port_b_pins_o,
  output logic [PORT_B_WIDTH-1:0] port_b_pins_oe,
  output logic [PORT_B_WIDTH-1:0] port_b_pins_pu,
  input wire logic [PORT_C_WIDTH-1:0] port_c_pins_i,
  output logic [PORT_C_WIDTH-1:0] port_c_pins_o,
  output logic [PORT_C_WIDTH-1:0] port_c_pins_oe,
  output logic [PORT_C_WIDTH-1:0] port_c_pins_pu,
  input wire logic [PORT_D_WIDTH-1:0] port_d_pins_i,
  output logic [PORT_D_WIDTH-1:0] port_d_pins_o,
  output logic [PORT_D_WIDTH-1:0] port_d_pins_oe,
  output logic [PORT_D_WIDTH-1:0] port_d_pins_pu,
  output logic clock_gen_in,
  output logic chip_reset,
  output logic cpu_clk_en,
  output logic io_clk_en,
  output logic adc_clk_en,
  output logic osc_en
);
  localparam int OSC_W = $clog2(OSC_CYCLES + 1);
  localparam logic [OSC_W-1:0] OSC_MAX = OSC_W'(OSC_CYCLES);

  function automatic logic [7:0] port_mask(input logic [1:0] idx);
    case (idx)
      2'(PORT_A): port_mask = 8'((1 << PORT_A_WIDTH) - 1);
      2'(PORT_B): port_mask = 8'((1 << PORT_B_WIDTH) - 1);
      2'(PORT_C): port_mask = 8'((1 << PORT_C_WIDTH) - 1);
      default: port_mask = 8'((1 << PORT_D_WIDTH) - 1);
    endcase
  endfunction

  function automatic logic port_page_hit(input logic [7:0] addr);
    port_page_hit = (addr[7:4] >= PORT_BASE_PAGE) && (addr[7:4] < PORT_BASE_PAGE + 4'(NUM_PORTS));
  endfunction

  reset_pin_if rif ();

  logic [NUM_PORTS-1:0][7:0] pin_raw;
  logic [NUM_PORTS-1:0][7:0] pin_meta;
  logic [NUM_PORTS-1:0][7:0] pin_sync;
  logic [NUM_PORTS-1:0][7:0] dir_reg;
  logic [NUM_PORTS-1:0][7:0] out_reg;
  logic [NUM_PORTS-1:0][7:0] pullup_reg;
  logic [NUM_PORTS-1:0][7:0] pad_o;
  logic [NUM_PORTS-1:0][7:0] pad_oe;
  logic [NUM_PORTS-1:0][7:0] pad_pu;
  logic [NUM_PORTS-1:0][7:0] pin_read;
  logic sleep_enable;
  sleep_mode_t sleep_mode;
  logic ext_reset_flag;
  power_state_t state;
  power_state_t next_state;
  logic [OSC_W-1:0] osc_cnt;
  logic pins_hiz;
  logic reset_pin_role;
  logic apb_write;
  logic [1:0] port_idx;
  logic [1:0] reg_sel;

  assign pin_raw[PORT_A] = {{(8 - PORT_A_WIDTH){1'b0}}, port_a_pins_i};
  assign pin_raw[PORT_B] = port_b_pins_i;
  assign pin_raw[PORT_C] = port_c_pins_i;
  assign pin_raw[PORT_D] = port_d_pins_i;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (ce) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  assign reset_pin_role = !reset_pin_disable_fuse;
  // Raw pin used only as a reset net; logic reads the synchronised copy
  assign rif.pin_async_n = reset_pin_disable_fuse | port_c_pins_i[SHARED_RESET_BIT];
  assign rif.pin_sync = reset_pin_disable_fuse | pin_sync[PORT_C][SHARED_RESET_BIT];

  reset_qualifier #(
    .MIN_PULSE_CYCLES(MIN_PULSE_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_reset_qualifier (
    .pclk(pclk),
    .ce(ce),
    .presetn(presetn),
    .rif(rif)
  );

  assign chip_reset = rif.chip_reset;
  // Release waits for the qualifier; assertion needs no clock edge
  assign pins_hiz = !presetn || rif.chip_reset;

  assign apb_write = psel && penable && pwrite;
  assign port_idx = 2'(paddr[7:4] - PORT_BASE_PAGE);
  assign reg_sel = paddr[3:2];
  // Every register answers in the access cycle, so no wait states are inserted
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_enable <= SLEEP_EN_RESET;
      sleep_mode <= MODE_IDLE;
    end else if (ce && apb_write && paddr == SLEEP_CTRL_OFFSET) begin
      sleep_enable <= pwdata[SLEEP_EN_BIT];
      sleep_mode <= sleep_mode_t'(pwdata[SLEEP_MODE_LSB +: 2]);
    end
  end

  // A long pulse in the same cycle as a clear keeps the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_reset_flag <= 1'b0;
    end else if (ce) begin
      if (rif.long_pulse) begin
        ext_reset_flag <= 1'b1;
      end else if (apb_write && paddr == STATUS_OFFSET && pwdata[STATUS_RST_FLAG_BIT]) begin
        ext_reset_flag <= 1'b0;
      end
    end
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dir_reg[p] <= PORT_REG_RESET;
          out_reg[p] <= PORT_REG_RESET;
          pullup_reg[p] <= PORT_REG_RESET;
        end else if (ce && apb_write && port_page_hit(paddr) && port_idx == 2'(p)) begin
          case (reg_sel)
            PORT_DIR_SEL: dir_reg[p] <= pwdata[7:0] & port_mask(2'(p));
            PORT_OUT_SEL: out_reg[p] <= pwdata[7:0] & port_mask(2'(p));
            PORT_PULLUP_SEL: pullup_reg[p] <= pwdata[7:0] & port_mask(2'(p));
            default: ;
          endcase
        end
      end
    end
  endgenerate

  always_comb begin
    pad_o = out_reg;
    pad_oe = dir_reg;
    pad_pu = pullup_reg & ~dir_reg;
    pin_read = pin_sync;
    if (reset_pin_role) begin
      pad_oe[PORT_C][SHARED_RESET_BIT] = 1'b0;
      pad_pu[PORT_C][SHARED_RESET_BIT] = 1'b1;
      pin_read[PORT_C][SHARED_RESET_BIT] = 1'b0;
    end
    if (clock_pin_select_fuse) begin
      pad_oe[PORT_B][CLOCK_PIN_BIT] = 1'b0;
      pad_pu[PORT_B][CLOCK_PIN_BIT] = 1'b0;
    end
    if (pins_hiz) begin
      pad_oe = '0;
      pad_pu = '0;
      if (reset_pin_role) begin
        pad_pu[PORT_C][SHARED_RESET_BIT] = 1'b1;
      end
    end
  end

  // Direct path: the pin is the clock source, so it must not be resampled
  assign clock_gen_in = clock_pin_select_fuse & port_b_pins_i[CLOCK_PIN_BIT];

  assign port_a_pins_o = pad_o[PORT_A][PORT_A_WIDTH-1:0];
  assign port_a_pins_oe = pad_oe[PORT_A][PORT_A_WIDTH-1:0];
  assign port_a_pins_pu = pad_pu[PORT_A][PORT_A_WIDTH-1:0];
  assign port_b_pins_o = pad_o[PORT_B];
  assign port_b_pins_oe = pad_oe[PORT_B];
  assign port_b_pins_pu = pad_pu[PORT_B];
  assign port_c_pins_o = pad_o[PORT_C];
  assign port_c_pins_oe = pad_oe[PORT_C];
  assign port_c_pins_pu = pad_pu[PORT_C];
  assign port_d_pins_o = pad_o[PORT_D];
  assign port_d_pins_oe = pad_oe[PORT_D];
  assign port_d_pins_pu = pad_pu[PORT_D];

  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (psel && !pwrite && paddr == SLEEP_CTRL_OFFSET) begin
      prdata[SLEEP_EN_BIT] = sleep_enable;
      prdata[SLEEP_MODE_LSB +: 2] = sleep_mode;
    end else if (psel && !pwrite && paddr == STATUS_OFFSET) begin
      prdata[STATUS_STATE_LSB +: 5] = state;
      prdata[STATUS_RST_FLAG_BIT] = ext_reset_flag;
      prdata[STATUS_PIN_ROLE_BIT] = reset_pin_role;
      prdata[STATUS_CLK_SEL_BIT] = clock_pin_select_fuse;
    end else if (psel && !pwrite && port_page_hit(paddr)) begin
      case (reg_sel)
        PORT_DIR_SEL: prdata[7:0] = dir_reg[port_idx];
        PORT_OUT_SEL: prdata[7:0] = out_reg[port_idx];
        PORT_PULLUP_SEL: prdata[7:0] = pullup_reg[port_idx];
        default: prdata[7:0] = pin_read[port_idx] & port_mask(port_idx);
      endcase
    end else if (psel && penable && paddr != SLEEP_CTRL_OFFSET && paddr != STATUS_OFFSET && !port_page_hit(paddr)) begin
      pslverr = 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_ACTIVE: begin
        if (sleep_cmd && sleep_enable) begin
          case (sleep_mode)
            MODE_IDLE: next_state = ST_IDLE;
            MODE_ADC_NOISE: next_state = ST_ADC_NOISE;
            MODE_POWER_DOWN: next_state = ST_POWER_DOWN;
            default: next_state = ST_ACTIVE;
          endcase
        end
      end
      ST_IDLE: if (wake_irq) begin
        next_state = ST_ACTIVE;
      end
      ST_ADC_NOISE: if (wake_irq) begin
        next_state = ST_ACTIVE;
      end
      ST_POWER_DOWN: if (wake_irq) begin
        next_state = ST_OSC_START;
      end
      ST_OSC_START: if (osc_cnt == OSC_MAX) begin
        next_state = ST_ACTIVE;
      end
      default: next_state = ST_ACTIVE;
    endcase
  end

  // Chip reset ends any sleep; register contents are untouched by sleep itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_ACTIVE;
    end else if (ce) begin
      state <= rif.chip_reset ? ST_ACTIVE : next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt <= '0;
    end else if (ce) begin
      if (state == ST_OSC_START && osc_cnt != OSC_MAX) begin
        osc_cnt <= osc_cnt + OSC_W'(1);
      end else if (state != ST_OSC_START) begin
        osc_cnt <= '0;
      end
    end
  end

  // cpu_clk_en comes straight from one state bit and osc_en is one state bit inverted; io_clk_en and adc_clk_en are ORs of several one-hot bits
  assign cpu_clk_en = state[0];
  assign io_clk_en = state[0] | state[1];
  assign adc_clk_en = state[0] | state[1] | state[2];
  assign osc_en = !state[3];
endmodule

// *** verilog/reset_pin_if.sv ***
// Signals between the top level and the reset pin qualifier
interface reset_pin_if;
  logic pin_async_n;
  logic pin_sync;
  logic chip_reset;
  logic long_pulse;
  modport qualifier (input pin_async_n, input pin_sync, output chip_reset, output long_pulse);
  modport top (output pin_async_n, output pin_sync, input chip_reset, input long_pulse);
endinterface

// *** verilog/reset_qualifier.sv ***
// Reset pin qualifier: asynchronous assertion, stretched release, long-pulse detect
module reset_qualifier
  import sys_ctrl_pkg::*;
#(
  parameter int MIN_PULSE_CYCLES = MIN_RESET_PULSE_CYCLES,
  parameter int HOLD_CYCLES = RESET_HOLD_CYCLES
) (
  input wire logic pclk,
  input wire logic ce,
  input wire logic presetn,
  reset_pin_if.qualifier rif
);
  localparam int LOW_W = $clog2(MIN_PULSE_CYCLES + 1);
  localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [LOW_W-1:0] LOW_MAX = LOW_W'(MIN_PULSE_CYCLES);
  localparam logic [HOLD_W-1:0] HOLD_MAX = HOLD_W'(HOLD_CYCLES);

  logic [LOW_W-1:0] low_cnt;
  logic [HOLD_W-1:0] hold_cnt;
  logic pin_rst_n;

  // The pin acts as a reset net so the chip resets with no clock running
  assign pin_rst_n = rif.pin_async_n & presetn;

  always_ff @(posedge pclk or negedge pin_rst_n) begin
    if (!pin_rst_n) begin
      hold_cnt <= '0;
      rif.chip_reset <= 1'b1;
    end else if (ce) begin
      if (!rif.pin_sync) begin
        hold_cnt <= '0;
      end else if (hold_cnt != HOLD_MAX) begin
        hold_cnt <= hold_cnt + HOLD_W'(1);
      end else begin
        rif.chip_reset <= 1'b0;
      end
    end
  end

  // Only lows of at least the minimum width are recorded as external resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= '0;
      rif.long_pulse <= 1'b0;
    end else if (ce) begin
      rif.long_pulse <= 1'b0;
      if (rif.pin_sync) begin
        low_cnt <= '0;
      end else if (low_cnt != LOW_MAX) begin
        low_cnt <= low_cnt + LOW_W'(1);
        rif.long_pulse <= (low_cnt == LOW_MAX - LOW_W'(1));
      end
    end
  end
endmodule

// *** verilog/sys_ctrl_pkg.sv ***
// Constants and types shared by the reset pin and sleep control block
package sys_ctrl_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Minimum qualifying low time on the reset pin, in ns
  localparam int MIN_RESET_PULSE_NS = 2500;
  localparam int MIN_RESET_PULSE_CYCLES = (MIN_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Time the chip reset is stretched after the pin returns high, in ns
  localparam int RESET_HOLD_NS = 1000;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Oscillator start-up wait on wake from power-down, in ns
  localparam int OSC_START_NS = 2000;
  localparam int OSC_START_CYCLES = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int NUM_PORTS = 4;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PORT_A_WIDTH = 4;
  localparam int PORT_B_WIDTH = 8;
  localparam int PORT_C_WIDTH = 8;
  localparam int PORT_D_WIDTH = 8;
  localparam int SHARED_RESET_BIT = 6;
  localparam int CLOCK_PIN_BIT = 6;

  localparam logic [7:0] SLEEP_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [3:0] PORT_BASE_PAGE = 4'h1;
  localparam logic [1:0] PORT_DIR_SEL = 2'h0;
  localparam logic [1:0] PORT_OUT_SEL = 2'h1;
  localparam logic [1:0] PORT_PULLUP_SEL = 2'h2;
  localparam logic [1:0] PORT_PIN_SEL = 2'h3;

  localparam int SLEEP_EN_BIT = 0;
  localparam int SLEEP_MODE_LSB = 1;
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_RST_FLAG_BIT = 8;
  localparam int STATUS_PIN_ROLE_BIT = 9;
  localparam int STATUS_CLK_SEL_BIT = 10;

  localparam logic SLEEP_EN_RESET = 1'b0;
  localparam logic [7:0] PORT_REG_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_ADC_NOISE = 2'h1,
    MODE_POWER_DOWN = 2'h2,
    MODE_RESERVED = 2'h3
  } sleep_mode_t;

  typedef enum logic [4:0] {
    ST_ACTIVE = 5'b00001,
    ST_IDLE = 5'b00010,
    ST_ADC_NOISE = 5'b00100,
    ST_POWER_DOWN = 5'b01000,
    ST_OSC_START = 5'b10000
  } power_state_t;
endpackage
